/* File: rtl/pbws_regs.svh */
`ifndef PBWS_REGS_SVH
`define PBWS_REGS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PBWS_OFF_CTRL 8'h00
`define PBWS_OFF_MASK 8'h04
`define PBWS_OFF_CFG 8'h08
`define PBWS_OFF_ADDR 8'h0C
`define PBWS_OFF_TIME 8'h10
`define PBWS_OFF_STAT 8'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PBWS_CTRL_RUN 0
`define PBWS_CTRL_ROAM 1
`define PBWS_MASK_FLD 4:0
`define PBWS_CFG_HOME_LEN 2:0
`define PBWS_CFG_ROAM_LEN 6:4
`define PBWS_CFG_BATCH 11:8
`define PBWS_ADDR_FLD 17:0
`define PBWS_TIME_CYC 5:0
`define PBWS_TIME_SS 10:8
`define PBWS_TIME_POS 27:16
`define PBWS_MASK_RST 5'h1F
`define PBWS_HOME_LEN_RST 3'h0
`define PBWS_ROAM_LEN_RST 3'h2
// ----------------------------------------
// Timing and frame structure
// ----------------------------------------
`define PBWS_CLK_HZ 32'h0262_5A00
`define PBWS_BIT_RATE 32'h0000_186A
`define PBWS_US_PER_S 32'h000F_4240
`define PBWS_WARM_US 32'h0000_2710
`define PBWS_CW_BITS 32'h0000_001E
`define PBWS_CW_LAST 5'h1D
`define PBWS_SUBSEQ_CW 12'h9C4
`define PBWS_BATCH_CW 12'h09A
`define PBWS_LAST_LEN 12'h0BE
`define PBWS_LAST_BATCH 4'hF
`define PBWS_SYNC_SI_CW 12'h005
`define PBWS_SS_LAST 3'h4
`define PBWS_CYC_LAST 6'h3B
`define PBWS_MATCH_MAX 3'h5
`define PBWS_MAX_ADDR 8'h8B
`define PBWS_TERM_MOD 8'h09
`define PBWS_TERM_OFS 8'h04
`define PBWS_KCAP_STD 8'h95
`define PBWS_KCAP_LAST 8'hB9
`endif

/* File: rtl/pbws_pkg.sv */
package pbws_pkg;
  typedef enum logic [2:0] {
    st_sleep = 3'b000,
    st_warm = 3'b001,
    st_sync = 3'b010,
    st_scan = 3'b011,
    st_hold = 3'b100
  } pbws_state_t;
endpackage

/* File: rtl/pbws_ahb_slave.sv */
`timescale 1ns/1ps
module pbws_ahb_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] rd_data,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wr_stb,
  output logic [7:0] wr_off,
  output logic [31:0] wr_data,
  output logic [7:0] rd_off
);
  // ----------------------------------------
  // Address phase capture
  // ----------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_off_q;
  logic [31:0] hrdata_q;
  wire logic take = hsel && htrans[1] && hready;

  // Read data is sampled in the address phase so hrdata comes from a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        wr_off_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata_q <= rd_data;
      end
    end
  end

  assign rd_off = haddr[7:0];
  assign wr_stb = wr_pend_q;
  assign wr_off = wr_off_q;
  assign wr_data = hwdata;
  assign hrdata = hrdata_q;
  // Zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // pbws_ahb_slave

/* File: rtl/pbws_addr_scan.sv */
`timescale 1ns/1ps
`include "pbws_regs.svh"
module pbws_addr_scan (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic cw_valid,
  input wire logic cw_is_term,
  input wire logic [17:0] cw_word,
  input wire logic [17:0] own_addr,
  input wire logic last_batch,
  output logic found,
  output logic done,
  output logic overflow,
  output logic [7:0] addr_count,
  output logic [7:0] k_max
);
  logic active_q;
  logic found_q;
  logic done_q;
  logic ovf_q;
  logic [7:0] addr_cnt_q;
  logic [3:0] term_q;

  function automatic logic [3:0] term_need(input logic [7:0] i);
    return 4'(`PBWS_TERM_MOD - ((i + `PBWS_TERM_OFS) % `PBWS_TERM_MOD));
  endfunction

  // ----------------------------------------
  // Address partition decode
  // ----------------------------------------
  wire logic [3:0] j_need = term_need(addr_cnt_q);
  wire logic is_addr = active_q && cw_valid && !cw_is_term;
  wire logic is_term = active_q && cw_valid && cw_is_term;
  wire logic lower = is_addr && (cw_word < own_addr);
  wire logic hit = is_addr && (cw_word == own_addr);
  wire logic too_many = is_addr && (addr_cnt_q == `PBWS_MAX_ADDR);
  wire logic term_end = is_term && ((term_q + 4'h1) == j_need);
  wire logic stop = lower || hit || too_many || term_end;
  wire logic [7:0] cap = last_batch ? `PBWS_KCAP_LAST : `PBWS_KCAP_STD;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
      addr_cnt_q <= 8'h00;
      term_q <= 4'h0;
      ovf_q <= 1'b0;
    end else if (start) begin
      active_q <= 1'b1;
      addr_cnt_q <= 8'h00;
      term_q <= 4'h0;
      ovf_q <= 1'b0;
    end else begin
      active_q <= active_q && !stop;
      if (is_addr && !too_many && !hit && !lower) begin
        addr_cnt_q <= addr_cnt_q + 8'h01;
      end
      if (is_term) begin
        term_q <= term_q + 4'h1;
      end
      if (too_many) begin
        ovf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      found_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      found_q <= hit;
      done_q <= stop && !hit;
    end
  end

  assign found = found_q;
  assign done = done_q;
  assign overflow = ovf_q;
  assign addr_count = addr_cnt_q;
  assign k_max = (cap - addr_cnt_q - 8'(j_need)) / `PBWS_TERM_MOD;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_term_count: assert property (
    is_term && !start && (term_q == j_need - 4'h1) |=> done && !active_q
  ) else $error("terminator count did not close the address partition");
  chk_lower_stop: assert property (
    lower && !start |=> done && !found && !active_q
  ) else $error("lower address did not stop the search");
  chk_ia_range: assert property (
    addr_cnt_q <= `PBWS_MAX_ADDR
  ) else $error("address count beyond range");
endmodule // pbws_addr_scan

/* File: rtl/pbws_scheduler.sv */
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pbws_regs.svh"
// How it works
// - Five subsequences per cycle, index tracked
// - Wake only for enabled subsequences
// - Mask bit four selects subsequence four
// - Mask resets to all ones
// - Sixteen batches, last one longer
// - Only own batch is monitored
// - Own address found: stay awake twelve seconds
// - Address count zero to 139 accepted
// - Terminator count is nine minus remainder
// - Codeblock bound from remaining partition room
// - Lower address stops the search
// - Warm up at least ten milliseconds before batch, in whole codewords
// - Stay awake through sync and info
// - Default mask keeps every subsequence active
// - Cycle chosen by low address bits
// - Home length resets 000, roaming 010
// - Cycle number wraps after 59
module pbws_scheduler #(
  parameter int BIT_CYC = `PBWS_CLK_HZ / `PBWS_BIT_RATE,
  parameter int WARM_CYC = (`PBWS_CLK_HZ / `PBWS_US_PER_S) * `PBWS_WARM_US
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cw_valid,
  input wire logic cw_is_term,
  input wire logic [17:0] cw_word,
  output logic radio_power_en
);
  // Warm-up lead in whole codewords, rounded up
  localparam int CW_CYC = BIT_CYC * `PBWS_CW_BITS;
  localparam int WARM_CW = (WARM_CYC + CW_CYC - 1) / CW_CYC;
  localparam logic [11:0] WARM_CW12 = 12'(WARM_CW);

  function automatic logic reg_sel(input logic [7:0] off, input logic [7:0] want);
    return off == want;
  endfunction

  function automatic logic cyc_hit(
    input logic [5:0] cyc,
    input logic [5:0] addr_lsb,
    input logic [2:0] len
  );
    logic [2:0] n;
    logic [5:0] m;
    n = (len > `PBWS_MATCH_MAX) ? `PBWS_MATCH_MAX : len;
    m = ~(6'h3F << n);
    return ((cyc ^ addr_lsb) & m) == 6'h00;
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic wr_stb;
  logic [7:0] wr_off;
  logic [31:0] wr_data;
  logic [7:0] rd_off;
  logic [31:0] rd_data;

  pbws_ahb_slave u_bus (
    .clk(clk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .rd_data(rd_data),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr_stb(wr_stb),
    .wr_off(wr_off),
    .wr_data(wr_data),
    .rd_off(rd_off)
  );

  logic run_q;
  logic roam_q;
  logic [4:0] mask_q;
  logic [2:0] home_cycle_match_length_q;
  logic [2:0] roaming_cycle_match_length_q;
  logic [3:0] batch_q;
  logic [17:0] own_addr_q;
  logic first_q;

  wire logic wr_ctrl = wr_stb && reg_sel(wr_off, `PBWS_OFF_CTRL);
  wire logic wr_mask = wr_stb && reg_sel(wr_off, `PBWS_OFF_MASK);
  wire logic wr_cfg = wr_stb && reg_sel(wr_off, `PBWS_OFF_CFG);
  wire logic wr_addr = wr_stb && reg_sel(wr_off, `PBWS_OFF_ADDR);
  wire logic time_wr = wr_stb && reg_sel(wr_off, `PBWS_OFF_TIME);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      roam_q <= 1'b0;
      mask_q <= `PBWS_MASK_RST;
      home_cycle_match_length_q <= `PBWS_HOME_LEN_RST;
      roaming_cycle_match_length_q <= `PBWS_ROAM_LEN_RST;
      batch_q <= 4'h0;
      own_addr_q <= 18'h0_0000;
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
      if (wr_ctrl) begin
        run_q <= wr_data[`PBWS_CTRL_RUN];
        roam_q <= wr_data[`PBWS_CTRL_ROAM];
      end
      if (wr_mask) begin
        mask_q <= wr_data[`PBWS_MASK_FLD];
      end
      if (wr_cfg) begin
        home_cycle_match_length_q <= wr_data[`PBWS_CFG_HOME_LEN];
        roaming_cycle_match_length_q <= wr_data[`PBWS_CFG_ROAM_LEN];
        batch_q <= wr_data[`PBWS_CFG_BATCH];
      end
      if (wr_addr) begin
        own_addr_q <= wr_data[`PBWS_ADDR_FLD];
      end
    end
  end

  // ----------------------------------------
  // Timebase: bit, codeword, subsequence, cycle
  // ----------------------------------------
  logic [15:0] bit_cnt_q;
  logic [4:0] cwb_q;
  logic [11:0] pos_q;
  logic [2:0] ss_q;
  logic [5:0] cyc_q;
  logic cw_start_q;

  wire logic bit_tick = bit_cnt_q == 16'(BIT_CYC - 1);
  wire logic cw_tick = bit_tick && (cwb_q == `PBWS_CW_LAST);
  wire logic pos_last = pos_q == (`PBWS_SUBSEQ_CW - 12'h001);
  wire logic ss_last = ss_q == `PBWS_SS_LAST;
  wire logic [11:0] pos_nx = pos_last ? 12'h000 : pos_q + 12'h001;
  wire logic [2:0] ss_nx = ss_last ? 3'h0 : ss_q + 3'h1;
  wire logic [5:0] cyc_nx = (cyc_q == `PBWS_CYC_LAST) ? 6'h00 : cyc_q + 6'h01;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 16'h0000;
      cwb_q <= 5'h00;
      cw_start_q <= 1'b0;
    end else begin
      bit_cnt_q <= (bit_tick || time_wr) ? 16'h0000 : bit_cnt_q + 16'h0001;
      if (time_wr || cw_tick) begin
        cwb_q <= 5'h00;
      end else if (bit_tick) begin
        cwb_q <= cwb_q + 5'h01;
      end
      cw_start_q <= cw_tick && !time_wr;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_q <= 12'h000;
      ss_q <= 3'h0;
      cyc_q <= 6'h00;
    end else if (time_wr) begin
      pos_q <= wr_data[`PBWS_TIME_POS];
      ss_q <= wr_data[`PBWS_TIME_SS];
      cyc_q <= wr_data[`PBWS_TIME_CYC];
    end else if (cw_tick) begin
      pos_q <= pos_nx;
      ss_q <= pos_last ? ss_nx : ss_q;
      cyc_q <= (pos_last && ss_last) ? cyc_nx : cyc_q;
    end
  end

  // ----------------------------------------
  // Own batch window
  // ----------------------------------------
  // Fifteen equal batches, the last runs to the end of the subsequence
  wire logic own_last = batch_q == `PBWS_LAST_BATCH;
  wire logic [11:0] tgt_pos = 12'(batch_q * `PBWS_BATCH_CW);
  wire logic [11:0] own_len = own_last ? `PBWS_LAST_LEN : `PBWS_BATCH_CW;
  wire logic [11:0] end_raw = tgt_pos + own_len;
  wire logic [11:0] end_pos = (end_raw == `PBWS_SUBSEQ_CW) ? 12'h000 : end_raw;
  // Early batches need the warm-up to start in the previous subsequence
  wire logic wrap = tgt_pos < WARM_CW12;
  wire logic [11:0] wake_pos = wrap ? (tgt_pos + `PBWS_SUBSEQ_CW - WARM_CW12)
                                    : (tgt_pos - WARM_CW12);
  wire logic [2:0] tgt_ss = wrap ? ss_nx : ss_q;
  wire logic [5:0] tgt_cyc = (wrap && ss_last) ? cyc_nx : cyc_q;
  wire logic [2:0] match_len = roam_q ? roaming_cycle_match_length_q : home_cycle_match_length_q;
  wire logic cyc_ok = cyc_hit(tgt_cyc, own_addr_q[5:0], match_len);
  wire logic ss_ok = mask_q[tgt_ss];
  wire logic wake_ok = run_q && cw_start_q && (pos_q == wake_pos) && ss_ok && cyc_ok;

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  pbws_pkg::pbws_state_t state_q;
  pbws_pkg::pbws_state_t state_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic power_q;
  logic scan_start;
  logic scan_found;
  logic scan_done;
  logic scan_ovf;
  logic [7:0] addr_count;
  logic [7:0] k_max;
  wire logic [11:0] cnt_inc = cnt_q + 12'h001;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    scan_start = 1'b0;
    case (state_q)
      pbws_pkg::st_sleep: begin
        if (wake_ok) begin
          state_d = pbws_pkg::st_warm;
        end
      end
      pbws_pkg::st_warm: begin
        if (cw_start_q && (pos_q == tgt_pos)) begin
          state_d = pbws_pkg::st_sync;
          cnt_d = 12'h000;
        end
      end
      pbws_pkg::st_sync: begin
        if (cw_start_q) begin
          cnt_d = cnt_inc;
          if (cnt_inc == `PBWS_SYNC_SI_CW) begin
            state_d = pbws_pkg::st_scan;
            scan_start = 1'b1;
          end
        end
      end
      pbws_pkg::st_scan: begin
        if (scan_found) begin
          state_d = pbws_pkg::st_hold;
          cnt_d = 12'h000;
        end else if (scan_done || (cw_start_q && (pos_q == end_pos))) begin
          state_d = pbws_pkg::st_sleep;
        end
      end
      pbws_pkg::st_hold: begin
        if (cw_start_q) begin
          cnt_d = cnt_inc;
          if (cnt_inc == `PBWS_SUBSEQ_CW) begin
            state_d = pbws_pkg::st_sleep;
          end
        end
      end
      default: begin
        state_d = pbws_pkg::st_sleep;
      end
    endcase
    // Stopping or re-timing always drops the radio
    if (!run_q || time_wr) begin
      state_d = pbws_pkg::st_sleep;
      scan_start = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= pbws_pkg::st_sleep;
      cnt_q <= 12'h000;
      power_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      power_q <= state_d != pbws_pkg::st_sleep;
    end
  end

  assign radio_power_en = power_q;

  pbws_addr_scan u_scan (
    .clk(clk),
    .reset_n(reset_n),
    .start(scan_start),
    .cw_valid(cw_valid && (state_q == pbws_pkg::st_scan)),
    .cw_is_term(cw_is_term),
    .cw_word(cw_word),
    .own_addr(own_addr_q),
    .last_batch(own_last),
    .found(scan_found),
    .done(scan_done),
    .overflow(scan_ovf),
    .addr_count(addr_count),
    .k_max(k_max)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [31:0] stat_word = {8'h00, k_max, addr_count, 3'h0, scan_ovf, power_q, state_q};
  wire logic [31:0] time_word = {4'h0, pos_q, 5'h00, ss_q, 2'h0, cyc_q};
  wire logic [31:0] cfg_word = {20'h0_0000, batch_q, 1'b0, roaming_cycle_match_length_q, 1'b0,
    home_cycle_match_length_q};
  always_comb begin
    case (rd_off)
      `PBWS_OFF_CTRL: rd_data = {30'h0000_0000, roam_q, run_q};
      `PBWS_OFF_MASK: rd_data = {27'h000_0000, mask_q};
      `PBWS_OFF_CFG: rd_data = cfg_word;
      `PBWS_OFF_ADDR: rd_data = {14'h0000, own_addr_q};
      `PBWS_OFF_TIME: rd_data = time_word;
      `PBWS_OFF_STAT: rd_data = stat_word;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_power_state: assert property (
    radio_power_en == (state_q != pbws_pkg::st_sleep)
  ) else $error("radio power does not follow the active window");
  chk_cycle_wrap: assert property (
    cw_tick && !time_wr && pos_last && ss_last && (cyc_q == `PBWS_CYC_LAST)
      |=> cyc_q == 6'h00 && ss_q == 3'h0 && pos_q == 12'h000
  ) else $error("cycle number did not wrap after the last cycle");
  chk_subseq_wrap: assert property (
    ss_q <= `PBWS_SS_LAST
  ) else $error("subsequence index out of range");
  chk_mask_gate: assert property (
    state_q == pbws_pkg::st_sleep && state_d == pbws_pkg::st_warm
      |-> mask_q[tgt_ss] && cyc_hit(tgt_cyc, own_addr_q[5:0], match_len)
  ) else $error("woke for a disabled subsequence or cycle");
  chk_mask_reset: assert property (
    first_q |-> mask_q == `PBWS_MASK_RST && home_cycle_match_length_q == `PBWS_HOME_LEN_RST
      && roaming_cycle_match_length_q == `PBWS_ROAM_LEN_RST
  ) else $error("configuration reset values wrong");
  chk_warm_lead: assert property (
    $rose(state_q == pbws_pkg::st_warm) |-> $past(pos_q) == wake_pos
  ) else $error("warm-up started at the wrong codeword");
  chk_sync_hold: assert property (
    state_q == pbws_pkg::st_sync && !cw_start_q && run_q && !time_wr
      |=> state_q == pbws_pkg::st_sync
  ) else $error("left sync partition early");
  chk_batch_start: assert property (
    $rose(state_q == pbws_pkg::st_sync) |-> $past(pos_q) == tgt_pos
  ) else $error("sync entered outside own batch start");
  chk_hold_enter: assert property (
    state_q == pbws_pkg::st_scan && scan_found && run_q && !time_wr
      |=> state_q == pbws_pkg::st_hold && cnt_q == 12'h000
  ) else $error("own address did not start the hold period");
  chk_hold_len: assert property (
    state_q == pbws_pkg::st_hold && cw_start_q && cnt_q < (`PBWS_SUBSEQ_CW - 12'h001)
      && run_q && !time_wr |=> state_q == pbws_pkg::st_hold
  ) else $error("hold period ended early");
  cov_wake: cover property ($rose(state_q == pbws_pkg::st_warm));
  cov_hold: cover property ($rose(state_q == pbws_pkg::st_hold));
  cov_early: cover property (state_q == pbws_pkg::st_scan && scan_done);
  cov_wrap: cover property (cw_tick && pos_last && ss_last);
endmodule // pbws_scheduler

/* File: tb/pbws_tx.sv */
`timescale 1ns/1ps
module pbws_tx (
  input wire logic clk,
  output logic cw_valid,
  output logic cw_is_term,
  output logic [17:0] cw_word
);
  initial begin
    cw_valid = 1'b0;
    cw_is_term = 1'b0;
    cw_word = 18'h0_0000;
  end
  // -------------------------
  // One codeword per call
  // -------------------------
  // Stale word inverted after the pulse so it never reads as fresh
  task automatic send(input logic [17:0] w, input logic t);
    @(posedge clk);
    cw_valid <= 1'b1;
    cw_is_term <= t;
    cw_word <= w;
    @(posedge clk);
    cw_valid <= 1'b0;
    cw_is_term <= ~t;
    cw_word <= ~w;
    repeat (3) @(posedge clk);
  endtask
endmodule // pbws_tx

/* File: tb/pbws_scheduler_test.sv */
`timescale 1ns/1ps
`include "pbws_regs.svh"
module pbws_scheduler_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic cw_valid;
  logic cw_is_term;
  logic [17:0] cw_word;
  logic radio_power_en;
  logic [31:0] rdat;
  logic hit;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;

  always #12.5 clk = ~clk;

  // Short bit time keeps a batch near 18k cycles
  pbws_scheduler #(.BIT_CYC(4), .WARM_CYC(240)) i_pbws_scheduler (
    .clk(clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cw_valid(cw_valid),
    .cw_is_term(cw_is_term), .cw_word(cw_word), .radio_power_en(radio_power_en));
  pbws_tx i_pbws_tx (.clk(clk), .cw_valid(cw_valid), .cw_is_term(cw_is_term),
    .cw_word(cw_word));

  // -------------------------
  // Helpers
  // -------------------------
  task automatic print_verdict;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 50000) begin
      n_fail++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic chkb(input logic s, input logic e);
    chk({31'h0000_0000, s}, {31'h0000_0000, e});
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    // Idle cycle so a read-back sees the new value
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wt(input int c);
    hit = 1'b0;
    while (c > 0 && hit !== 1'b1) begin
      @(posedge clk);
      hit = radio_power_en;
      c--;
    end
  endtask

  function automatic logic [31:0] tw(input logic [2:0] ss, input logic [5:0] cy,
    input logic [11:0] pos);
    return {4'h0, pos, 5'h00, ss, 2'h0, cy};
  endfunction

  task automatic arm(input logic [17:0] own, input logic [31:0] ctl, cfg, msk, tm);
    ahb(1'b1, `PBWS_OFF_ADDR, {14'h0000, own});
    ahb(1'b1, `PBWS_OFF_CFG, cfg);
    ahb(1'b1, `PBWS_OFF_MASK, msk);
    ahb(1'b1, `PBWS_OFF_CTRL, ctl);
    ahb(1'b1, `PBWS_OFF_TIME, tm);
    wt(300);
  endtask

  task automatic go_scan(input logic [17:0] own, input logic [31:0] cfg, input logic [11:0] p);
    arm(own, 32'h0000_0001, cfg, 32'h0000_001F, tw(3'h0, 6'h00, p));
    chkb(hit, 1'b1);
    rd(`PBWS_OFF_TIME);
    // Two codewords of lead at the bench's short bit time
    chk({20'h0_0000, rdat[27:16]}, {20'h0_0000, p + 12'h002});
    repeat (815) @(posedge clk);
    rd(`PBWS_OFF_STAT);
    chk(rdat & 32'h0000_000F, 32'h0000_000A);
    repeat (30) @(posedge clk);
    rd(`PBWS_OFF_STAT);
    chk(rdat & 32'h0000_000F, 32'h0000_000B);
  endtask

  task automatic cyc_case(input logic [31:0] ctl, cfg, input logic [5:0] cy,
    input logic e);
    arm(18'h0_0003, ctl, cfg, 32'h0000_001F, tw(3'h0, cy, 12'h096));
    chkb(hit, e);
  endtask

  // -------------------------
  // Scenarios
  // -------------------------
  task automatic s_reset;
    chkb(radio_power_en, 1'b0);
    rd(`PBWS_OFF_MASK);
    chk(rdat, 32'h0000_001F);
    rd(`PBWS_OFF_CFG);
    chk(rdat, 32'h0000_0020);
    rd(8'h18);
    chk(rdat, 32'h0000_0000);
  endtask

  task automatic s_scan_low;
    go_scan(18'h0_0100, 32'h0000_0100, 12'h096);
    i_pbws_tx.send(18'h0_0300, 1'b0);
    i_pbws_tx.send(18'h0_0200, 1'b0);
    chkb(radio_power_en, 1'b1);
    i_pbws_tx.send(18'h0_00FF, 1'b0);
    chkb(radio_power_en, 1'b0);
  endtask

  task automatic s_hold;
    go_scan(18'h0_0100, 32'h0000_0100, 12'h096);
    i_pbws_tx.send(18'h0_0300, 1'b0);
    i_pbws_tx.send(18'h0_0100, 1'b0);
    // Past the end of the batch: a match must outlive it
    repeat (18300) @(posedge clk);
    rd(`PBWS_OFF_STAT);
    chk(rdat & 32'h0000_000F, 32'h0000_000C);
    chkb(radio_power_en, 1'b1);
  endtask

  task automatic s_term;
    go_scan(18'h0_0010, 32'h0000_0100, 12'h096);
    for (int k = 0; k < 5; k++) i_pbws_tx.send(18'h0_0300 - 18'(k), 1'b0);
    rd(`PBWS_OFF_STAT);
    chk({16'h0000, rdat[23:8]}, 32'h0000_0F05);
    for (int k = 0; k < 8; k++) i_pbws_tx.send(18'h0_0000, 1'b1);
    chkb(radio_power_en, 1'b1);
    i_pbws_tx.send(18'h0_0000, 1'b1);
    chkb(radio_power_en, 1'b0);
  endtask

  // Last batch of the subsequence: wider codeblock bound
  task automatic s_last;
    go_scan(18'h0_0010, 32'h0000_0F00, 12'h902);
    for (int k = 0; k < 4; k++) i_pbws_tx.send(18'h0_0300 - 18'(k), 1'b0);
    rd(`PBWS_OFF_STAT);
    chk({16'h0000, rdat[23:8]}, 32'h0000_1404);
    i_pbws_tx.send(18'h0_0000, 1'b1);
    chkb(radio_power_en, 1'b0);
  endtask

  task automatic s_mask;
    for (int s = 0; s < 5; s++) begin
      arm(18'h0_0010, 32'h0000_0001, 32'h0000_0100, 32'h0000_0001 << s,
        tw(3'(s), 6'h00, 12'h096));
      chkb(hit, 1'b1);
      arm(18'h0_0010, 32'h0000_0001, 32'h0000_0100, 32'h0000_0001 << s,
        tw(3'((s + 1) % 5), 6'h00, 12'h096));
      chkb(hit, 1'b0);
    end
  endtask

  task automatic s_cycle;
    cyc_case(32'h0000_0001, 32'h0000_0122, 6'h03, 1'b1);
    cyc_case(32'h0000_0001, 32'h0000_0122, 6'h02, 1'b0);
    cyc_case(32'h0000_0001, 32'h0000_0122, 6'h3B, 1'b1);
    cyc_case(32'h0000_0003, 32'h0000_0152, 6'h23, 1'b1);
    cyc_case(32'h0000_0003, 32'h0000_0152, 6'h3B, 1'b0);
    arm(18'h0_0003, 32'h0000_0001, 32'h0000_0100, 32'h0000_001F,
      tw(3'h4, 6'h3B, 12'h9C2));
    rd(`PBWS_OFF_TIME);
    chk(rdat & 32'h0FFF_073F, 32'h0000_0000);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    s_reset();
    s_scan_low();
    s_term();
    s_last();
    s_mask();
    s_cycle();
    s_hold();
    print_verdict;
  end
endmodule // pbws_scheduler_test
